// File: ret_rot_cfg.svh
// Encoding, field and timing constants for the return and rotate executor
`ifndef RET_ROT_CFG_SVH
`define RET_ROT_CFG_SVH
`define OP_INT_RETURN 24'h064000
`define OP_PLAIN_RETURN 24'h060000
`define OP_LIT_RETURN_PREFIX 8'h05
`define OP_ROT_FILE_PREFIX 9'h1AD
`define OP_ROT_REG_PREFIX 9'h1A5
`define OP_NOP 24'h000000
`define STACK_STEP 16'h0002
`define FILE_DEST_WORK0 1'b1
`define SIZE_BYTE 1'b1
`define RETURN_CYCLES 2'h3
`define RETURN_CYCLES_EXC 2'h2
`define SP_RESET 16'h0800
`define MODE_DIRECT 3'h0
`define MODE_INDIRECT 3'h1
`define MODE_POST_DEC 3'h2
`define MODE_POST_INC 3'h3
`define MODE_PRE_DEC 3'h4
`define MODE_PRE_INC 3'h5
`endif

// File: ret_rot_pkg.sv
// Types shared by the return and rotate executor
package ret_rot_pkg;
    typedef enum logic [1:0] {
        IDLE_ST = 2'h0,
        POP_HI_ST = 2'h1,
        POP_LO_ST = 2'h3,
        FINISH_ST = 2'h2
    } ret_state_type;
    typedef enum logic [1:0] {
        KIND_INT = 2'h0,
        KIND_LIT = 2'h1,
        KIND_PLAIN = 2'h2
    } ret_kind_type;
    typedef struct packed {
        logic repeat_active_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
        logic carry;
    } flags_type;
    typedef struct packed {
        logic valid;
        logic is_file;
        logic [12:0] addr;
        logic [15:0] data;
    } mem_write_type;
endpackage

// File: ret_rot_exec.sv
// Return and rotate-left-through-carry execution logic
// Contract
// (RULE1) Interrupt return pops status byte, level bit 3 and PC top bits
// (RULE2) Interrupt return: second pop loads the low 16 PC bits
// (RULE3) Restored status and level bit 3 bring back the pre-interrupt priority
// (RULE4) Interrupt return updates priority bits and repeat, N, overflow, Z, C flags
// (RULE5) Software clears the pending interrupt flag before the interrupt return
// (RULE6) Interrupt return opcode is 0x064000
// (RULE7) Returns take three cycles, two when an exception is pending
// (RULE8) Literal return pops upper then lower PC, stack drops 4, literal to register
// (RULE9) Literal is unsigned, 0..255 byte form, 0..1023 word form, ten bits
// (RULE10) Literal return: prefix 0x05, size bit, ten literal bits, register nibble
// (RULE11) Plain return pops two words, stack drops 4, NOP into instruction register
// (RULE12) Plain return opcode is 0x060000
// (RULE13) File rotate: old carry to bit 0, shift up, top bit to carry
// (RULE14) File rotate result goes to working register 0 or file address 0..8191
// (RULE15) File rotate decodes 1101 0110 1, size, destination, 13-bit address
// (RULE16) Register rotate shifts source into dest bits 7:1 or 15:1 through carry
// (RULE17) Register rotate decodes 1101 0010 1, size, modes and register fields
// (RULE18) Register rotate supports direct and indirect modes with pre/post inc/dec; only the destination pointer is updated, the source register is not
// (RULE19) Rotates set N from top bit, Z on zero, finish in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ret_rot_cfg.svh"
module ret_rot_exec
    import ret_rot_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic exception_pending,
    output logic busy,
    output logic done,
    // Stack and operand memory
    output logic [15:0] mem_rd_addr,
    input wire logic [15:0] mem_rd_data,
    output var mem_write_type mem_wr,
    // Working registers
    input wire logic [15:0] work_reg_file [16],
    output logic [3:0] target_work_reg,
    output logic [15:0] target_data,
    output logic target_wr,
    output logic [3:0] ptr_reg_sel,
    output logic [15:0] ptr_reg_data,
    output logic ptr_reg_wr,
    // Core state
    output logic [15:0] stack_pointer_reg,
    output logic [22:0] pc_reg,
    output logic pc_load,
    output logic [7:0] status_word,
    output logic [3:0] priority_level,
    output logic [15:0] core_control_reg,
    output logic [23:0] instr_reg
);
    ret_state_type state_reg;
    ret_kind_type kind_reg;
    logic [3:0] lit_dest_reg;
    logic [9:0] lit_value_reg;
    logic lit_byte_reg;
    logic exc_reg;

    function automatic logic [1:0] decode_return(input logic [23:0] w);
        // 00 none, 01 interrupt, 10 plain, 11 literal
        if (w == `OP_INT_RETURN) begin // RULE6
            return 2'h1;
        end else if (w == `OP_PLAIN_RETURN) begin // RULE12
            return 2'h2;
        end else if (w[23:16] == `OP_LIT_RETURN_PREFIX && !w[15]) begin // RULE10
            return 2'h3;
        end
        return 2'h0;
    endfunction

    function automatic logic [15:0] ea_addr(input logic [2:0] mode, input logic [15:0] r,
                                             input logic byte_op);
        logic [15:0] step;
        step = byte_op ? 16'h0001 : 16'h0002;
        case (mode)
            `MODE_PRE_DEC: return r - step;
            `MODE_PRE_INC: return r + step;
            default: return r;
        endcase
    endfunction

    function automatic logic [15:0] ea_update(input logic [2:0] mode, input logic [15:0] r,
                                               input logic byte_op);
        logic [15:0] step;
        step = byte_op ? 16'h0001 : 16'h0002;
        case (mode)
            `MODE_POST_DEC, `MODE_PRE_DEC: return r - step;
            `MODE_POST_INC, `MODE_PRE_INC: return r + step;
            default: return r;
        endcase
    endfunction

    logic [1:0] ret_code;
    logic is_rot_file, is_rot_reg, rot_byte, start_ret;
    logic [2:0] dmode, smode;
    logic [3:0] dreg, sreg;
    logic [15:0] rot_src, rot_res;
    logic rot_carry, rot_neg, rot_zero;
    flags_type flags_reg;
    logic [15:0] dst_ea;

    assign ret_code = decode_return(instr_word);
    assign is_rot_file = instr_word[23:15] == `OP_ROT_FILE_PREFIX; // RULE15
    assign is_rot_reg = instr_word[23:15] == `OP_ROT_REG_PREFIX; // RULE17
    assign rot_byte = instr_word[14] == `SIZE_BYTE;
    assign dmode = instr_word[13:11];
    assign dreg = instr_word[10:7];
    assign smode = instr_word[6:4];
    assign sreg = instr_word[3:0];
    assign start_ret = instr_valid && state_reg == IDLE_ST && ret_code != 2'h0;
    assign busy = state_reg != IDLE_ST;
    assign dst_ea = ea_addr(dmode, work_reg_file[dreg], rot_byte); // RULE18

    // Operand read address: stack during returns, file or indirect source otherwise
    always_comb begin
        mem_rd_addr = stack_pointer_reg - `STACK_STEP;
        if (state_reg == POP_LO_ST) begin
            mem_rd_addr = stack_pointer_reg - `STACK_STEP; // RULE2
        end else if (state_reg == IDLE_ST && is_rot_file) begin
            mem_rd_addr = {3'h0, instr_word[12:0]};
        end else if (state_reg == IDLE_ST && is_rot_reg) begin
            mem_rd_addr = ea_addr(smode, work_reg_file[sreg], rot_byte); // RULE18
        end
    end

    // Rotate datapath, single cycle
    always_comb begin
        if (is_rot_reg && smode == `MODE_DIRECT) begin
            rot_src = work_reg_file[sreg];
        end else begin
            rot_src = mem_rd_data;
        end
        rot_res = {rot_src[14:0], flags_reg.carry}; // RULE13 RULE16
        if (rot_byte) begin
            rot_res = {8'h00, rot_src[6:0], flags_reg.carry};
            rot_carry = rot_src[7];
            rot_neg = rot_res[7]; // RULE19
            rot_zero = rot_res[7:0] == 8'h00;
        end else begin
            rot_carry = rot_src[15];
            rot_neg = rot_res[15]; // RULE19
            rot_zero = rot_res == 16'h0000;
        end
    end

    // Return sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= IDLE_ST;
            kind_reg <= KIND_PLAIN;
            exc_reg <= 1'b0;
        end else begin
            case (state_reg)
                IDLE_ST: begin
                    if (start_ret) begin
                        state_reg <= POP_HI_ST;
                        kind_reg <= ret_code == 2'h1 ? KIND_INT :
                                    ret_code == 2'h3 ? KIND_LIT : KIND_PLAIN;
                        exc_reg <= exception_pending;
                    end
                end
                POP_HI_ST: begin
                    state_reg <= POP_LO_ST;
                end
                POP_LO_ST: begin
                    // Pending exception skips the trailing fill cycle
                    state_reg <= exc_reg ? IDLE_ST : FINISH_ST; // RULE7
                end
                FINISH_ST: state_reg <= IDLE_ST; // RULE7
                default: state_reg <= IDLE_ST;
            endcase
        end
    end

    assign done = (state_reg == FINISH_ST) || (state_reg == POP_LO_ST && exc_reg) ||
                  (state_reg == IDLE_ST && instr_valid && (is_rot_file || is_rot_reg));

    // Literal capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lit_dest_reg <= 4'h0;
            lit_value_reg <= 10'h000;
            lit_byte_reg <= 1'b0;
        end else if (start_ret) begin
            lit_dest_reg <= instr_word[3:0];
            lit_value_reg <= instr_word[13:4]; // RULE9
            lit_byte_reg <= instr_word[14];
        end
    end

    // Stack pointer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_reg <= `SP_RESET;
        end else if (state_reg == POP_HI_ST || state_reg == POP_LO_ST) begin
            stack_pointer_reg <= stack_pointer_reg - `STACK_STEP; // RULE1 RULE8 RULE11
        end
    end

    // Program counter restore
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= 23'h000000;
            pc_load <= 1'b0;
        end else begin
            pc_load <= 1'b0;
            if (state_reg == POP_HI_ST) begin
                pc_reg[22:16] <= mem_rd_data[6:0]; // RULE1 RULE8
            end else if (state_reg == POP_LO_ST) begin
                pc_reg[15:0] <= mem_rd_data; // RULE2
                pc_load <= 1'b1;
            end
        end
    end

    // Status and priority; interrupt return restores all of them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= '0;
            priority_level <= 4'h0;
            core_control_reg <= 16'h0000;
        end else if (state_reg == POP_HI_ST && kind_reg == KIND_INT) begin
            flags_reg.repeat_active_flag <= mem_rd_data[12]; // RULE4
            flags_reg.negative <= mem_rd_data[11];
            flags_reg.overflow_flag <= mem_rd_data[10];
            flags_reg.zero <= mem_rd_data[9];
            flags_reg.carry <= mem_rd_data[8];
            priority_level <= {mem_rd_data[7], mem_rd_data[15:13]}; // RULE1 RULE3
            core_control_reg[3] <= mem_rd_data[7]; // RULE3
        end else if (state_reg == IDLE_ST && instr_valid && (is_rot_file || is_rot_reg)) begin
            flags_reg.carry <= rot_carry; // RULE13 RULE16
            flags_reg.negative <= rot_neg; // RULE19
            flags_reg.zero <= rot_zero;
        end
    end

    assign status_word = {priority_level[2:0], flags_reg.repeat_active_flag, flags_reg.negative,
                          flags_reg.overflow_flag, flags_reg.zero, flags_reg.carry};

    // Results to registers and memory
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_wr <= 1'b0;
            target_work_reg <= 4'h0;
            target_data <= 16'h0000;
            mem_wr <= '0;
            ptr_reg_wr <= 1'b0;
            ptr_reg_sel <= 4'h0;
            ptr_reg_data <= 16'h0000;
        end else begin
            target_wr <= 1'b0;
            mem_wr.valid <= 1'b0;
            ptr_reg_wr <= 1'b0;
            if (state_reg == POP_LO_ST && kind_reg == KIND_LIT) begin
                target_wr <= 1'b1; // RULE8
                target_work_reg <= lit_dest_reg;
                target_data <= lit_byte_reg ? {8'h00, lit_value_reg[7:0]} : // RULE9
                               {6'h00, lit_value_reg};
            end else if (state_reg == IDLE_ST && instr_valid && is_rot_file) begin
                // Byte form keeps the upper half; odd file addresses are not lane-steered
                if (instr_word[13] == `FILE_DEST_WORK0) begin
                    target_wr <= 1'b1; // RULE14
                    target_work_reg <= 4'h0;
                    target_data <= rot_byte ? {work_reg_file[0][15:8], rot_res[7:0]} : rot_res;
                end else begin
                    mem_wr <= '{valid: 1'b1, is_file: 1'b1, addr: instr_word[12:0],
                                data: rot_byte ? {mem_rd_data[15:8], rot_res[7:0]} :
                                rot_res}; // RULE14
                end
            end else if (state_reg == IDLE_ST && instr_valid && is_rot_reg) begin
                if (dmode == `MODE_DIRECT) begin
                    target_wr <= 1'b1;
                    target_work_reg <= dreg;
                    target_data <= rot_byte ? {work_reg_file[dreg][15:8], rot_res[7:0]} : rot_res;
                end else begin
                    mem_wr <= '{valid: 1'b1, is_file: 1'b0,
                                addr: dst_ea[12:0],
                                data: rot_res}; // RULE18
                    ptr_reg_wr <= 1'b1;
                    ptr_reg_sel <= dreg;
                    ptr_reg_data <= ea_update(dmode, work_reg_file[dreg], rot_byte);
                end
            end
        end
    end

    // Instruction register flush on interrupt and plain return
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg <= `OP_NOP;
        end else if (start_ret && ret_code != 2'h3) begin
            instr_reg <= `OP_NOP; // RULE11
        end else if (instr_valid && state_reg == IDLE_ST) begin
            instr_reg <= instr_word;
        end
    end

    property p_sp_two_pops;
        @(posedge ref_clk) disable iff (!rst_n)
        start_ret |=> ##2 (stack_pointer_reg == $past(stack_pointer_reg, 3) - 16'h0004);
    endproperty
    a_sp_two_pops: assert property (p_sp_two_pops) else $error("stack not lowered by 4"); // RULE8
    property p_ret_len;
        @(posedge ref_clk) disable iff (!rst_n)
        (start_ret && !exception_pending) |=> !done ##1 !done ##1 done;
    endproperty
    a_ret_len: assert property (p_ret_len) else $error("return not three cycles"); // RULE7
    property p_ret_exc;
        @(posedge ref_clk) disable iff (!rst_n)
        (start_ret && exception_pending) |=> !done ##1 done ##1 state_reg == IDLE_ST;
    endproperty
    a_ret_exc: assert property (p_ret_exc) else $error("exception return not two"); // RULE7
    property p_ipl_restore;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == POP_HI_ST && kind_reg == KIND_INT) |=>
            priority_level[3] == $past(mem_rd_data[7]);
    endproperty
    a_ipl_restore: assert property (p_ipl_restore) else $error("level bit 3 wrong"); // RULE3
    property p_pc_low;
        @(posedge ref_clk) disable iff (!rst_n)
        state_reg == POP_LO_ST |=> pc_load && pc_reg[15:0] == $past(mem_rd_data);
    endproperty
    a_pc_low: assert property (p_pc_low) else $error("pc low not loaded"); // RULE2
    property p_rot_carry;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == IDLE_ST && instr_valid && is_rot_file && !rot_byte) |=>
            flags_reg.carry == $past(rot_src[15]);
    endproperty
    a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong"); // RULE13
    property p_rot_lsb;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_reg == IDLE_ST && instr_valid && is_rot_reg && dmode == `MODE_DIRECT) |=>
            target_wr && target_data[0] == $past(flags_reg.carry);
    endproperty
    a_rot_lsb: assert property (p_rot_lsb) else $error("old carry not in bit 0"); // RULE16
    property p_lit_write;
        @(posedge ref_clk) disable iff (!rst_n)
        (start_ret && ret_code == 2'h3) |=> ##2 target_wr;
    endproperty
    a_lit_write: assert property (p_lit_write) else $error("literal not written"); // RULE8
    property p_nop_fill;
        @(posedge ref_clk) disable iff (!rst_n)
        (start_ret && ret_code != 2'h3) |=> instr_reg == `OP_NOP;
    endproperty
    a_nop_fill: assert property (p_nop_fill) else $error("no nop loaded"); // RULE11
    c_int_ret: cover property (@(posedge ref_clk) start_ret && ret_code == 2'h1);
    c_lit_ret: cover property (@(posedge ref_clk) start_ret && ret_code == 2'h3);
    c_exc_ret: cover property (@(posedge ref_clk) start_ret && exception_pending);
    c_rot_file: cover property (@(posedge ref_clk) instr_valid && is_rot_file && !busy);
endmodule
`default_nettype wire

// File: data_mem_model.sv
// Behavioural data memory holding the software stack and the operands
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
    import ret_rot_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Read side, answered within the same cycle
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    // Registered write side
    input wire mem_write_type wr
);
    logic [15:0] cells [4096];
    initial begin
        // Every untouched word differs, so a wrong address cannot read a lucky match
        for (int i = 0; i < 4096; i++) begin
            cells[i] = 16'(i) ^ 16'hA5A5;
        end
    end
    assign rd_data = cells[rd_addr[12:1]];
    always @(posedge ref_clk) begin
        if (wr.valid) begin
            cells[wr.addr[12:1]] <= wr.data;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the return and rotate executor
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ret_rot_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [23:0] instr_word = 24'h000000;
    logic exception_pending = 1'b0;
    logic busy, done, target_wr, ptr_reg_wr, pc_load, pc_seen;
    logic [15:0] mem_rd_addr, mem_rd_data, target_data, ptr_reg_data, tgt_dat;
    logic [15:0] stack_pointer_reg, core_control_reg;
    logic [15:0] wregs [16];
    logic [3:0] target_work_reg, ptr_reg_sel, priority_level, tgt_reg;
    logic [22:0] pc_reg;
    logic [7:0] status_word;
    logic [23:0] instr_reg;
    mem_write_type mem_wr;
    int err_count = 0;
    int compares = 0;
    int n;

    always #50 ref_clk = ~ref_clk;

    ret_rot_exec DUT (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .exception_pending(exception_pending), .busy(busy),
        .done(done), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr(mem_wr),
        .work_reg_file(wregs), .target_work_reg(target_work_reg), .target_data(target_data),
        .target_wr(target_wr), .ptr_reg_sel(ptr_reg_sel), .ptr_reg_data(ptr_reg_data),
        .ptr_reg_wr(ptr_reg_wr), .stack_pointer_reg(stack_pointer_reg), .pc_reg(pc_reg),
        .pc_load(pc_load), .status_word(status_word), .priority_level(priority_level),
        .core_control_reg(core_control_reg), .instr_reg(instr_reg));

    data_mem_model mem (.ref_clk(ref_clk), .rd_addr(mem_rd_addr), .rd_data(mem_rd_data),
        .wr(mem_wr));

    // Working register file kept by the bench, as the core would
    always @(posedge ref_clk) begin
        if (target_wr) begin
            wregs[target_work_reg] <= target_data;
        end
        if (ptr_reg_wr) begin
            wregs[ptr_reg_sel] <= ptr_reg_data;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flags(input logic nf, input logic zf, input logic cf);
        chk(32'({status_word[3], status_word[1], status_word[0]}), 32'({nf, zf, cf}), "flags");
    endtask

    task automatic put(input logic [15:0] a, input logic [15:0] v);
        mem.cells[a[12:1]] = v;
    endtask

    task automatic ret_go(input logic [23:0] op, input logic exc, output int cyc);
        cyc = 0;
        pc_seen = 1'b0;
        tgt_reg = 4'h0;
        tgt_dat = 16'h0000;
        @(posedge ref_clk);
        instr_word <= op;
        instr_valid <= 1'b1;
        exception_pending <= exc;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        exception_pending <= 1'b0;
        for (int k = 1; k <= 5; k++) begin
            @(negedge ref_clk);
            if (k == 1) chk(32'(busy), 32'h1, "return busy");
            if (done === 1'b1 && cyc == 0) cyc = k;
            if (pc_load === 1'b1) pc_seen = 1'b1;
            if (target_wr === 1'b1) begin
                tgt_reg = target_work_reg;
                tgt_dat = target_data;
            end
            if (k < 5) @(posedge ref_clk);
        end
    endtask

    task automatic rot_go(input logic [23:0] op);
        @(posedge ref_clk);
        instr_word <= op;
        instr_valid <= 1'b1;
        @(negedge ref_clk);
        chk(32'(done), 32'h1, "rotate done");
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic t_reset;
        @(negedge ref_clk);
        chk(32'({stack_pointer_reg, mem_rd_addr}), 32'h080007FE, "reset stack");
        // Unknown opcode must leave everything but the instruction register alone
        @(posedge ref_clk);
        instr_word <= 24'hFFFFFF;
        instr_valid <= 1'b1;
        @(negedge ref_clk);
        chk(32'(done), 32'h0, "unknown done");
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        chk(32'({busy, target_wr, mem_wr.valid, stack_pointer_reg}), 32'h0800, "unknown");
        $display("test reset finished");
    endtask

    task automatic t_int_return;
        // No interrupt is left pending when the return is issued
        put(16'h07FE, 16'hA9C5);
        put(16'h07FC, 16'h7008);
        ret_go(24'h064000, 1'b0, n);
        chk(32'(n), 32'd3, "int return cycles");
        chk(32'(stack_pointer_reg), 32'h07FC, "int return sp");
        chk(32'({pc_seen, pc_reg}), 32'h00C57008, "int return pc");
        chk(32'(status_word), 32'hA9, "int return status");
        chk(32'({priority_level, core_control_reg[3]}), 32'h1B, "level");
        $display("test interrupt return finished");
    endtask

    task automatic t_plain_return;
        put(16'h07FA, 16'h0001);
        put(16'h07F8, 16'h0A06);
        ret_go(24'h060000, 1'b1, n);
        chk(32'(n), 32'd2, "plain return cycles");
        chk(32'({stack_pointer_reg, 9'h000, pc_reg[22:16]}), 32'h07F80001, "plain sp");
        chk(32'(pc_reg[15:0]), 32'h0A06, "plain pc");
        chk(32'(instr_reg), 32'h0, "plain nop");
        $display("test plain return finished");
    endtask

    task automatic t_lit(input logic b, input logic [9:0] lit, input logic [3:0] rn,
        input logic exc, input logic [15:0] sp0, input logic [15:0] hi, input logic [15:0] lo);
        put(sp0 - 16'h0002, hi);
        put(sp0 - 16'h0004, lo);
        ret_go({8'h05, 1'b0, b, lit, rn}, exc, n);
        chk(32'(n), exc ? 32'd2 : 32'd3, "literal cycles");
        chk(32'(stack_pointer_reg), 32'(sp0 - 16'h0004), "literal sp");
        chk(32'({pc_seen, pc_reg}), 32'({1'b1, hi[6:0], lo}), "literal pc");
        chk(32'({tgt_reg, tgt_dat}), 32'({rn, 6'h00, b ? {2'h0, lit[7:0]} : lit}),
            "literal value");
        $display("test literal return finished");
    endtask

    task automatic t_reg_direct;
        rot_go({8'hD2, 1'b1, 1'b1, 3'h0, 4'h3, 3'h0, 4'h0});
        chk(32'({target_wr, target_work_reg, target_data}), 32'h1358ED, "reg rotate");
        chk_flags(1'b1, 1'b0, 1'b0);
        $display("test register rotate finished");
    endtask

    task automatic t_reg_indirect;
        put(16'h2008, 16'hC041);
        @(posedge ref_clk);
        instr_word <= {8'hD2, 1'b1, 1'b0, 3'h1, 4'h8, 3'h3, 4'h2};
        instr_valid <= 1'b1;
        @(negedge ref_clk);
        chk(32'(done), 32'h1, "first done");
        @(posedge ref_clk);
        instr_word <= {8'hD2, 1'b1, 1'b0, 3'h4, 4'h8, 3'h0, 4'h0};
        @(negedge ref_clk);
        chk(32'({done, mem_wr.valid, mem_wr.addr, mem_wr.data}), 32'h694E8082, "post inc");
        chk_flags(1'b1, 1'b0, 1'b1);
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        @(negedge ref_clk);
        chk(32'({ptr_reg_wr, ptr_reg_sel, ptr_reg_data}), 32'h18094C, "pre dec ptr");
        chk(32'({mem_wr.valid, mem_wr.addr, mem_wr.data}), 32'h294C32ED, "pre dec");
        chk_flags(1'b0, 1'b0, 1'b1);
        $display("test indirect rotate finished");
    endtask

    task automatic t_file_rot;
        put(16'h0820, 16'h216E);
        put(16'h1232, 16'hE880);
        rot_go({8'hD6, 1'b1, 1'b0, 1'b1, 13'h0820});
        chk(32'({mem_wr.valid, target_wr, target_work_reg, target_data}), 32'h1042DD, "to w0");
        chk_flags(1'b0, 1'b0, 1'b0);
        rot_go({8'hD6, 1'b1, 1'b1, 1'b0, 13'h1232});
        chk(32'({target_wr, mem_wr.valid, mem_wr.is_file, mem_wr.addr, mem_wr.data}),
            32'h7232E800, "to file");
        chk_flags(1'b0, 1'b1, 1'b1);
        $display("test file rotate finished");
    endtask

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 16; i++) wregs[i] = 16'h0000;
        wregs[0] = 16'h9976;
        wregs[2] = 16'h2008;
        wregs[3] = 16'h5879;
        wregs[8] = 16'h094E;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset;
        t_int_return;
        t_plain_return;
        t_lit(1'b0, 10'h3FF, 4'h5, 1'b0, 16'h07F8, 16'h0001, 16'h7008);
        t_lit(1'b1, 10'h0AB, 4'h9, 1'b1, 16'h07F4, 16'h0000, 16'h0450);
        t_reg_direct;
        t_reg_indirect;
        t_file_rot;
        test_done;
    end

    // Whole run is well under two hundred cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done;
    end
endmodule
`default_nettype wire
